// File: shared/dpc_pkg.sv
package dpc_pkg;
  localparam int CODE_W   = 8;
  localparam int TAP_W    = CODE_W + 1;
  localparam int N_CH     = 2;
  localparam int N_SLOT   = 4;
  localparam int SLOT_W   = 2;
  localparam int CTRL_W   = 3;
  localparam int ADDR_W   = 4;

  localparam logic [TAP_W-1:0]  FULL_SCALE = 9'h100;
  localparam logic [TAP_W-1:0]  TAP_ZERO   = 9'h000;
  localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;

  // control bit positions and value after reset
  localparam int CTRL_ALLOW_BIT = 0;
  localparam int CTRL_PROG_BIT  = 1;
  localparam int CTRL_GAIN_BIT  = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h3;

  // command address fields
  localparam int ADDR_BCAST_BIT = 3;
  localparam int ADDR_SIDE_BIT  = 2;
  localparam int ADDR_CH_BIT    = 0;
  localparam logic [N_SLOT-1:0] MASK_ALL = 4'hf;
  localparam logic [N_SLOT-1:0] MASK_WB  = 4'h5;

  // scale enter/exit flag sits in data bit 0
  localparam int SCALE_ENTER_BIT = 0;

  // readback selectors in data bits 1:0
  localparam logic [1:0] RD_SEL_INPUT = 2'h0;
  localparam logic [1:0] RD_SEL_NVM   = 2'h1;
  localparam logic [1:0] RD_SEL_CTRL  = 2'h2;
  localparam logic [1:0] RD_SEL_WIPER = 2'h3;

  // preset walks all slots: one read, then one load per slot
  localparam logic [2:0] PRESET_LAST = 3'h4;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_WR_INPUT = 4'h1,
    OP_WR_WIPER = 4'h2,
    OP_READ     = 4'h3,
    OP_COPY_IN  = 4'h4,
    OP_STORE    = 4'h5,
    OP_RECALL   = 4'h6,
    OP_WR_NVM   = 4'h7,
    OP_TOP      = 4'h8,
    OP_BOTTOM   = 4'h9,
    OP_SW_RESET = 4'ha,
    OP_WR_CTRL  = 4'hb
  } dpc_op_t;

  typedef enum logic {ST_PRESET, ST_RUN} dpc_state_t;
endpackage

// File: shared/dpc_mem_if.sv
`timescale 1ns/100ps
interface dpc_mem_if;
  logic                        wr_en;
  logic [dpc_pkg::SLOT_W-1:0]  wr_addr;
  logic [dpc_pkg::CODE_W-1:0]  wr_data;
  logic [dpc_pkg::SLOT_W-1:0]  rd_addr;
  logic [dpc_pkg::CODE_W-1:0]  rd_data;

  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// File: src/dpc_nvm.sv
`timescale 1ns/100ps
module dpc_nvm (
  // clock
  input wire logic clk,
  // access port
  dpc_mem_if.mem   mem
);
  // stored values survive sys_rst on purpose; only the power-up image is zero
  logic [dpc_pkg::CODE_W-1:0] cell_reg [dpc_pkg::N_SLOT] = '{default: dpc_pkg::CODE_RESET};
  logic [dpc_pkg::CODE_W-1:0] rd_data_reg;

  always_ff @(posedge clk) begin
    if (mem.wr_en) begin
      cell_reg[mem.wr_addr] <= mem.wr_data;
    end
    rd_data_reg <= cell_reg[mem.rd_addr];
  end

  assign mem.rd_data = rd_data_reg;
endmodule

// File: src/dpc_core.sv
`timescale 1ns/100ps
// How it works
// - wiper code decodes to exactly one tap
// - potentiometer mode: A and B sides complementary
// - gain mode: A side follows own register
// - top and bottom scale states per channel
// - top scale sets A path to zero steps and wiper-to-B to full scale
// - update bit clear freezes wipers at stored
// - program bit clear blocks nonvolatile stores
// - mode bit selects potentiometer or gain mode
// - after reset, stored values preset wiper registers
module dpc_core (
  // clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    sys_rst,
  // command port
  input  wire logic                                    cmd_valid,
  input  wire dpc_pkg::dpc_op_t                        cmd_op,
  input  wire logic [dpc_pkg::ADDR_W-1:0]              cmd_addr,
  input  wire logic [dpc_pkg::CODE_W-1:0]              cmd_data,
  output logic                                         busy,
  // readback
  output logic                                         resp_valid,
  output logic [dpc_pkg::CODE_W-1:0]                   resp_data,
  // channel state
  output logic [dpc_pkg::CTRL_W-1:0]                   control_out,
  output logic [dpc_pkg::N_CH-1:0][dpc_pkg::TAP_W-1:0] wb_tap,
  output logic [dpc_pkg::N_CH-1:0][dpc_pkg::TAP_W-1:0] aw_tap,
  output logic [dpc_pkg::N_CH-1:0]                     top_scale,
  output logic [dpc_pkg::N_CH-1:0]                     bottom_scale
);
  dpc_mem_if mem_if ();

  dpc_nvm u_nvm (
    .clk (clk),
    .mem (mem_if)
  );

  dpc_pkg::dpc_state_t              state_reg;
  dpc_pkg::dpc_state_t              state_next;
  logic [2:0]                       pcnt_reg;
  logic [dpc_pkg::CTRL_W-1:0]       channel_control_reg;
  logic [dpc_pkg::CODE_W-1:0]       input_reg [dpc_pkg::N_SLOT];
  logic [dpc_pkg::CODE_W-1:0]       resistor_dac_register_reg [dpc_pkg::N_SLOT];
  logic [dpc_pkg::N_CH-1:0]         top_reg;
  logic [dpc_pkg::N_CH-1:0]         bot_reg;
  logic                             rd_pend_reg;
  logic [1:0]                       rd_sel_reg;
  logic [dpc_pkg::SLOT_W-1:0]       rd_slot_reg;

  // channel/side targets of an address
  function automatic logic [dpc_pkg::N_SLOT-1:0] slot_mask(
    input logic [dpc_pkg::ADDR_W-1:0] a,
    input logic                       gain
  );
    logic [dpc_pkg::N_SLOT-1:0] m;
    m = '0;
    if (a[dpc_pkg::ADDR_BCAST_BIT]) begin
      m = gain ? dpc_pkg::MASK_ALL : dpc_pkg::MASK_WB;
    end else if (gain || !a[dpc_pkg::ADDR_SIDE_BIT]) begin
      m[{a[dpc_pkg::ADDR_CH_BIT], a[dpc_pkg::ADDR_SIDE_BIT]}] = 1'b1;
    end
    return m;
  endfunction

  // returns {wiper-to-B steps, A-to-wiper steps}
  function automatic logic [2*dpc_pkg::TAP_W-1:0] tap_decode(
    input logic [dpc_pkg::CODE_W-1:0] wb,
    input logic [dpc_pkg::CODE_W-1:0] aw,
    input logic                       gain,
    input logic                       top,
    input logic                       bot
  );
    logic [dpc_pkg::TAP_W-1:0] w;
    logic [dpc_pkg::TAP_W-1:0] a;
    w = {1'b0, wb};
    a = gain ? {1'b0, aw} : dpc_pkg::FULL_SCALE - {1'b0, wb};
    if (top) begin
      w = dpc_pkg::FULL_SCALE;
      a = dpc_pkg::TAP_ZERO;
    end else if (bot) begin
      w = dpc_pkg::TAP_ZERO;
      a = dpc_pkg::FULL_SCALE;
    end
    return {w, a};
  endfunction

  wire                        gain_mode  = channel_control_reg[dpc_pkg::CTRL_GAIN_BIT];
  wire                        accept     = cmd_valid && (state_reg == dpc_pkg::ST_RUN);
  wire                        wiper_ok   = accept && channel_control_reg[dpc_pkg::CTRL_ALLOW_BIT];
  wire                        prog_ok    = accept && channel_control_reg[dpc_pkg::CTRL_PROG_BIT];
  wire [dpc_pkg::N_SLOT-1:0]  tgt        = slot_mask(cmd_addr, gain_mode);
  wire [dpc_pkg::SLOT_W-1:0]  cmd_slot   = {cmd_addr[dpc_pkg::ADDR_CH_BIT],
                                            cmd_addr[dpc_pkg::ADDR_SIDE_BIT]};
  wire                        do_wr_in   = accept && (cmd_op == dpc_pkg::OP_WR_INPUT);
  wire                        do_wr_wiper = wiper_ok && (cmd_op == dpc_pkg::OP_WR_WIPER);
  wire                        do_copy    = wiper_ok && (cmd_op == dpc_pkg::OP_COPY_IN);
  wire                        do_top     = wiper_ok && (cmd_op == dpc_pkg::OP_TOP);
  wire                        do_bot     = wiper_ok && (cmd_op == dpc_pkg::OP_BOTTOM);
  wire                        do_store   = prog_ok && (cmd_op == dpc_pkg::OP_STORE);
  wire                        do_wr_nvm  = prog_ok && (cmd_op == dpc_pkg::OP_WR_NVM);
  wire                        do_ctrl    = accept && (cmd_op == dpc_pkg::OP_WR_CTRL);
  wire                        do_read    = accept && (cmd_op == dpc_pkg::OP_READ);
  wire                        do_scale   = do_top || do_bot;
  // clearing the update bit reloads stored values so the wipers really sit there
  wire                        start_preset = accept && ((cmd_op == dpc_pkg::OP_RECALL)
                                || (cmd_op == dpc_pkg::OP_SW_RESET)
                                || (do_ctrl && !cmd_data[dpc_pkg::CTRL_ALLOW_BIT]));
  wire                        load_en    = (state_reg == dpc_pkg::ST_PRESET)
                                           && (pcnt_reg != 3'h0);
  wire [dpc_pkg::SLOT_W-1:0]  load_slot  = pcnt_reg[1:0] - 2'h1;
  wire                        enter      = cmd_data[dpc_pkg::SCALE_ENTER_BIT];

  assign mem_if.wr_en   = do_store || do_wr_nvm;
  assign mem_if.wr_addr = do_store ? cmd_slot : cmd_addr[dpc_pkg::SLOT_W-1:0];
  assign mem_if.wr_data = do_store ? resistor_dac_register_reg[cmd_slot] : cmd_data;
  assign mem_if.rd_addr = (state_reg == dpc_pkg::ST_PRESET) ? pcnt_reg[1:0]
                                                             : cmd_addr[dpc_pkg::SLOT_W-1:0];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dpc_pkg::ST_PRESET: if (pcnt_reg == dpc_pkg::PRESET_LAST) state_next = dpc_pkg::ST_RUN;
      dpc_pkg::ST_RUN:    if (start_preset) state_next = dpc_pkg::ST_PRESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= dpc_pkg::ST_PRESET;
      pcnt_reg  <= 3'h0;
      busy      <= 1'b1;
    end else begin
      state_reg <= state_next;
      pcnt_reg  <= (state_reg == dpc_pkg::ST_PRESET) ? pcnt_reg + 3'h1 : 3'h0;
      busy      <= (state_next == dpc_pkg::ST_PRESET);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_control_reg <= dpc_pkg::CTRL_RESET;
    end else if (do_ctrl) begin
      channel_control_reg <= cmd_data[dpc_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < dpc_pkg::N_SLOT; i++) begin
      if (sys_rst) begin
        input_reg[i]                 <= dpc_pkg::CODE_RESET;
        resistor_dac_register_reg[i] <= dpc_pkg::CODE_RESET;
      end else begin
        if (do_wr_in && tgt[i]) input_reg[i] <= cmd_data;
        if (load_en && (load_slot == i[dpc_pkg::SLOT_W-1:0])) begin
          resistor_dac_register_reg[i] <= mem_if.rd_data;
        end else if (do_wr_wiper && tgt[i]) begin
          resistor_dac_register_reg[i] <= cmd_data;
        end else if (do_copy && tgt[i]) begin
          resistor_dac_register_reg[i] <= input_reg[i];
        end
      end
    end
  end

  // a wiper write on a channel leaves both scale states
  always_ff @(posedge clk) begin
    for (int c = 0; c < dpc_pkg::N_CH; c++) begin
      if (sys_rst || state_reg == dpc_pkg::ST_PRESET) begin
        top_reg[c] <= 1'b0;
        bot_reg[c] <= 1'b0;
      end else if (tgt[2*c] || tgt[2*c+1]) begin
        if (do_top) begin
          top_reg[c] <= enter;
          if (enter) bot_reg[c] <= 1'b0;
        end else if (do_bot) begin
          bot_reg[c] <= enter;
          if (enter) top_reg[c] <= 1'b0;
        end else if ((do_wr_wiper || do_copy) && !do_scale) begin
          top_reg[c] <= 1'b0;
          bot_reg[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_tap       <= '0;
      aw_tap       <= '0;
      top_scale    <= '0;
      bottom_scale <= '0;
      control_out  <= dpc_pkg::CTRL_RESET;
    end else begin
      for (int c = 0; c < dpc_pkg::N_CH; c++) begin
        {wb_tap[c], aw_tap[c]} <= tap_decode(resistor_dac_register_reg[2*c],
                                             resistor_dac_register_reg[2*c+1],
                                             gain_mode, top_reg[c], bot_reg[c]);
      end
      top_scale    <= top_reg;
      bottom_scale <= bot_reg;
      control_out  <= channel_control_reg;
    end
  end

  // every readback takes two edges so the stored-value path lines up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_pend_reg <= 1'b0;
      rd_sel_reg  <= dpc_pkg::RD_SEL_INPUT;
      rd_slot_reg <= '0;
      resp_valid  <= 1'b0;
      resp_data   <= dpc_pkg::CODE_RESET;
    end else begin
      rd_pend_reg <= do_read;
      rd_sel_reg  <= cmd_data[1:0];
      rd_slot_reg <= cmd_slot;
      resp_valid  <= rd_pend_reg;
      unique case (rd_sel_reg)
        dpc_pkg::RD_SEL_INPUT: resp_data <= input_reg[rd_slot_reg];
        dpc_pkg::RD_SEL_NVM:   resp_data <= mem_if.rd_data;
        dpc_pkg::RD_SEL_CTRL:  resp_data <= {5'h00, channel_control_reg};
        dpc_pkg::RD_SEL_WIPER: resp_data <= resistor_dac_register_reg[rd_slot_reg];
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_preset_done;
    ##[1:6] !busy;
  endsequence
  sequence s_normal0;
    !gain_mode && !top_reg[0] && !bot_reg[0];
  endsequence

  a_preset_after_reset: assert property (
    disable iff (1'b0) $fell(sys_rst) |-> s_preset_done)
    else $error("preset did not finish after reset");
  a_ctrl_reset_value: assert property (
    disable iff (1'b0) sys_rst |=> channel_control_reg == dpc_pkg::CTRL_RESET)
    else $error("control value after reset wrong");
  a_wiper_write_blocked: assert property (
    (accept && cmd_op == dpc_pkg::OP_WR_WIPER && !channel_control_reg[dpc_pkg::CTRL_ALLOW_BIT])
    |=> resistor_dac_register_reg[0] == $past(resistor_dac_register_reg[0]))
    else $error("wiper changed while protected");
  a_nvm_write_gated: assert property (
    (accept && (cmd_op == dpc_pkg::OP_STORE || cmd_op == dpc_pkg::OP_WR_NVM)
     && !channel_control_reg[dpc_pkg::CTRL_PROG_BIT])
    |=> u_nvm.cell_reg[0] == $past(u_nvm.cell_reg[0])
        && u_nvm.cell_reg[1] == $past(u_nvm.cell_reg[1])
        && u_nvm.cell_reg[2] == $past(u_nvm.cell_reg[2])
        && u_nvm.cell_reg[3] == $past(u_nvm.cell_reg[3]))
    else $error("stored value written while programming disabled");
  a_pot_complement: assert property (
    s_normal0 |=> (aw_tap[0] + wb_tap[0]) == dpc_pkg::FULL_SCALE)
    else $error("potentiometer sides not complementary");
  a_code_decode: assert property (
    s_normal0 |=> wb_tap[0] == {1'b0, $past(resistor_dac_register_reg[0])})
    else $error("wiper tap does not match code");
  a_gain_independent: assert property (
    (gain_mode && !top_reg[0] && !bot_reg[0])
    |=> aw_tap[0] == {1'b0, $past(resistor_dac_register_reg[1])})
    else $error("gain mode A side not from its own register");
  a_top_scale_step: assert property (
    top_reg[1] |=> aw_tap[1] == dpc_pkg::TAP_ZERO && wb_tap[1] == dpc_pkg::FULL_SCALE)
    else $error("top scale taps wrong");
  a_bottom_scale: assert property (
    (bot_reg[1] && !top_reg[1]) |=> wb_tap[1] == dpc_pkg::TAP_ZERO && bottom_scale[1])
    else $error("bottom scale taps wrong");
  a_broadcast_write: assert property (
    (do_wr_in && cmd_addr[dpc_pkg::ADDR_BCAST_BIT])
    |=> input_reg[0] == $past(cmd_data) && input_reg[2] == $past(cmd_data))
    else $error("broadcast missed a channel");
endmodule

// File: tb/dpc_host_model.sv
`timescale 1ns/100ps
module dpc_host_model (
  // clock and device status
  input  wire logic                       clk,
  input  wire logic                       busy,
  // command request
  output logic                            cmd_valid,
  output dpc_pkg::dpc_op_t                cmd_op,
  output logic [dpc_pkg::ADDR_W-1:0]      cmd_addr,
  output logic [dpc_pkg::CODE_W-1:0]      cmd_data
);
  // idle cycles inserted before each request, to play a slow host
  int unsigned gap = 0;

  initial begin
    cmd_valid = 1'b0;
    cmd_op    = dpc_pkg::OP_NOP;
    cmd_addr  = 4'h0;
    cmd_data  = 8'h00;
  end

  // a dropped command gives no sign, so valid waits for busy to clear, for at most 100 cycles
  task automatic issue(input dpc_pkg::dpc_op_t op, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    repeat (gap) begin
      @(posedge clk);
      #1;
    end
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_addr  = a;
    cmd_data  = d;
    @(posedge clk);
    #1;
    // released address and data lines carry the inverse so stale values cannot pass
    cmd_valid = 1'b0;
    cmd_op    = dpc_pkg::OP_NOP;
    cmd_addr  = ~a;
    cmd_data  = ~d;
  endtask
endmodule

// File: tb/dual_pot_control_and_decode_tb_top.sv
`timescale 1ns/100ps
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module dual_pot_control_and_decode_tb_top;
  logic             clk;
  logic             sys_rst;
  logic             cmd_valid;
  dpc_pkg::dpc_op_t cmd_op;
  logic [3:0]       cmd_addr;
  logic [7:0]       cmd_data;
  logic             busy;
  logic             resp_valid;
  logic [7:0]       resp_data;
  logic [2:0]       control_out;
  logic [1:0][8:0]  wb_tap;
  logic [1:0][8:0]  aw_tap;
  logic [1:0]       top_scale;
  logic [1:0]       bottom_scale;
  int               fails;
  int               num_checks;
  logic [7:0]       exp_q[$];
  logic [7:0]       mon_exp;
  logic [31:0]      lfsr;
  logic [7:0]       d;
  logic [7:0]       d1;
  logic [7:0]       d2;
  logic [7:0]       s0;
  logic [7:0]       s1;

  dpc_core dpc_core_inst (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(busy), .resp_valid(resp_valid),
    .resp_data(resp_data), .control_out(control_out), .wb_tap(wb_tap), .aw_tap(aw_tap),
    .top_scale(top_scale), .bottom_scale(bottom_scale)
  );
  dpc_host_model dpc_host_model_inst (
    .clk(clk), .busy(busy), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [8:0] inv(input logic [7:0] v);
    return 9'h100 - {1'b0, v};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input dpc_pkg::dpc_op_t op, input logic [3:0] a, input logic [7:0] v);
    dpc_host_model_inst.issue(op, a, v);
    step(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] sel, input logic [7:0] e);
    exp_q.push_back(e);
    dpc_host_model_inst.issue(dpc_pkg::OP_READ, a, {6'h00, sel});
    step(3);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    step(2);
    while (busy !== 1'b0 && n < 50) begin
      step(1);
      n++;
    end
    `CHK(busy, 1'b0)
  endtask
  task automatic taps(input int ch, input logic [8:0] wb, input logic [8:0] aw);
    `CHK(wb_tap[ch], wb)
    `CHK(aw_tap[ch], aw)
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // readback notes are taken off in the order the reads were issued
  always @(posedge clk) begin
    if (resp_valid === 1'b1) begin
      mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : ~resp_data;
      `CHK(resp_data, mon_exp)
    end
  end

  initial begin
    #50000;
    fails++;
    conclude();
  end

  initial begin
    lfsr       = 32'h0001551c;
    fails      = 0;
    num_checks = 0;
    sys_rst    = 1'b1;
    step(2);
    `CHK(busy, 1'b1)
    `CHK(control_out, 3'h3)
    sys_rst = 1'b0;
    wait_idle();
    rd(4'h0, 2'h2, 8'h03);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
      cmd(dpc_pkg::OP_WR_WIPER, 4'(i % 2), d);
      taps(i % 2, {1'b0, d}, inv(d));
      rd(4'(i % 2), 2'h3, d);
    end
    // slow host while addressing is exercised
    dpc_host_model_inst.gap = 2;
    d = rnd();
    cmd(dpc_pkg::OP_WR_WIPER, 4'h8, d);
    taps(0, {1'b0, d}, inv(d));
    taps(1, {1'b0, d}, inv(d));
    cmd(dpc_pkg::OP_WR_WIPER, 4'h4, ~d);
    taps(0, {1'b0, d}, inv(d));
    dpc_host_model_inst.gap = 0;
    d = rnd();
    // broadcast input write reaches both channels
    cmd(dpc_pkg::OP_WR_INPUT, 4'h8, d);
    rd(4'h1, 2'h0, d);
    rd(4'h0, 2'h0, d);
    cmd(dpc_pkg::OP_COPY_IN, 4'h1, 8'h00);
    taps(1, {1'b0, d}, inv(d));
    cmd(dpc_pkg::OP_TOP, 4'h1, 8'h01);
    `CHK({top_scale, bottom_scale}, 4'h8)
    taps(1, 9'h100, 9'h000);
    cmd(dpc_pkg::OP_BOTTOM, 4'h1, 8'h01);
    `CHK({top_scale, bottom_scale}, 4'h2)
    taps(1, 9'h000, 9'h100);
    cmd(dpc_pkg::OP_BOTTOM, 4'h1, 8'h00);
    `CHK({top_scale, bottom_scale}, 4'h0)
    s0 = rnd();
    s1 = rnd();
    cmd(dpc_pkg::OP_WR_NVM, 4'h0, s0);
    cmd(dpc_pkg::OP_WR_NVM, 4'h1, s1);
    rd(4'h1, 2'h1, s1);
    cmd(dpc_pkg::OP_RECALL, 4'h0, 8'h00);
    wait_idle();
    taps(0, {1'b0, s0}, inv(s0));
    cmd(dpc_pkg::OP_WR_CTRL, 4'h0, 8'h07);
    `CHK(control_out, 3'h7)
    d1 = rnd();
    d2 = rnd();
    cmd(dpc_pkg::OP_WR_WIPER, 4'h0, d1);
    cmd(dpc_pkg::OP_WR_WIPER, 4'h4, d2);
    taps(0, {1'b0, d1}, {1'b0, d2});
    cmd(dpc_pkg::OP_STORE, 4'h0, 8'h01);
    rd(4'h0, 2'h1, d1);
    // clearing update and program bits freezes wipers and stored values
    cmd(dpc_pkg::OP_WR_CTRL, 4'h0, 8'h04);
    wait_idle();
    taps(0, {1'b0, d1}, {1'b0, s1});
    cmd(dpc_pkg::OP_WR_WIPER, 4'h0, ~d1);
    taps(0, {1'b0, d1}, {1'b0, s1});
    cmd(dpc_pkg::OP_WR_NVM, 4'h0, ~d1);
    rd(4'h0, 2'h1, d1);
    rd(4'h0, 2'h2, 8'h04);
    sys_rst = 1'b1;
    step(2);
    `CHK(control_out, 3'h3)
    sys_rst = 1'b0;
    wait_idle();
    taps(0, {1'b0, d1}, inv(d1));
    // software reset reloads the stored codes over a fresh wiper write
    cmd(dpc_pkg::OP_WR_WIPER, 4'h0, ~d1);
    taps(0, {1'b0, ~d1}, inv(~d1));
    cmd(dpc_pkg::OP_SW_RESET, 4'h0, 8'h00);
    wait_idle();
    taps(0, {1'b0, d1}, inv(d1));
    step(5);
    `CHK(exp_q.size(), 0)
    conclude();
  end
endmodule
